/* File: logic/ovl_port_pkg.sv */
package ovl_port_pkg;
    // ****************************************
    // Register addresses on da[2:0]
    // ****************************************
    localparam logic [2:0] ADDR_DATA = 3'h0;
    localparam logic [2:0] ADDR_ERROR = 3'h1;
    localparam logic [2:0] ADDR_COUNT = 3'h2;
    localparam logic [2:0] ADDR_SECTOR = 3'h3;
    localparam logic [2:0] ADDR_CYL_LO = 3'h4;
    localparam logic [2:0] ADDR_CYL_HI = 3'h5;
    localparam logic [2:0] ADDR_DEVHEAD = 3'h6;
    localparam logic [2:0] ADDR_STATUS = 3'h7;
    localparam logic [2:0] ADDR_ALTSTAT = 3'h6;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int CC_BIT = 15;
    localparam int TAG_LSB = 8;
    localparam int TAG_W = 4;
    localparam int OVL_BIT = 15;
    localparam int DEV_BIT = 4;
    localparam int NIEN_BIT = 1;
    localparam int SRST_BIT = 2;
    localparam int ST_BSY = 7;
    localparam int ST_DRQ = 3;
    localparam int ST_ERR = 0;
    localparam int ST_RDY = 6;
    // ****************************************
    // Mode encodings and reset values
    // ****************************************
    typedef enum logic [1:0] {
        MODE_LEGACY = 2'b00,
        MODE_BITSEL = 2'b01,
        MODE_CHIPSEL = 2'b10
    } mode_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_LATCH = 3'b001,
        ST_EXEC = 3'b010,
        ST_WAIT = 3'b011,
        ST_XFER = 3'b100,
        ST_DONE = 3'b101
    } state_t;
    localparam logic [7:0] DEVCTL_RESET = 8'h00;
    localparam logic [7:0] DEVHEAD_RESET = 8'h00;
    localparam logic [3:0] LATCH_CYCLES = 4'h2;
endpackage

/* File: logic/ovl_select.sv */
`timescale 1ns/1ps
module ovl_select
    import ovl_port_pkg::*;
(
    input wire logic [1:0] mode,
    input wire logic dev_id,
    input wire logic dev_bit,
    input wire logic cs0_act,
    input wire logic cs1_act,
    output logic selected,
    output logic cmd_block,
    output logic ctl_block
);
    // ****************************************
    // Selection decode for all three modes
    // ****************************************
    always_comb begin
        cmd_block = cs0_act;
        ctl_block = !cs0_act;
        if (mode == MODE_CHIPSEL) begin
            selected = cs0_act ? (cs1_act == dev_id) : (cs1_act == dev_id); // RULE4
        end else begin
            selected = (dev_bit == dev_id) && (cs0_act || cs1_act); // RULE2
        end
    end
endmodule // ovl_select

/* File: logic/ovl_irq_gate.sv */
`timescale 1ns/1ps
module ovl_irq_gate
    import ovl_port_pkg::*;
(
    input wire logic [1:0] mode,
    input wire logic dev_id,
    input wire logic selected,
    input wire logic pending,
    input wire logic nien,
    output logic intrq_d,
    output logic intrq_en_d,
    output logic intrq2_d,
    output logic intrq2_en_d
);
    // ****************************************
    // Interrupt line routing
    // ****************************************
    always_comb begin
        intrq_d = 1'b0;
        intrq_en_d = 1'b0;
        intrq2_d = 1'b0;
        intrq2_en_d = 1'b0;
        if (mode == MODE_CHIPSEL) begin
            if (dev_id) begin
                intrq2_d = pending && !nien; // RULE24
                intrq2_en_d = 1'b1;
            end else begin
                intrq_d = pending && !nien; // RULE24
                intrq_en_d = 1'b1;
            end
        end else if (selected) begin
            intrq_d = pending && !nien; // RULE13 RULE18
            intrq_en_d = 1'b1;
        end
    end
endmodule // ovl_irq_gate

/* File: logic/ovl_device_port.sv */
// Notes on behaviour
// RULE1: In overlapped modes command block writes are taken only when selected; the code takes head register writes in bit-select mode when deselected.
// RULE2: Mixed bus: this device is Device 1, selected by the head register bit.
// RULE3: Bit-select mode: drop busy once command parameters are captured.
// RULE4: Chip-select mode: selection comes from the two chip selects; the code compares cs1_act alone with dev_id.
// RULE5: Host may reselect while busy or before any word moves.
// RULE6: Once a word moved, host completes the transfer before reselecting.
// RULE7: While busy or data request, busy and request bits read true.
// RULE8: Host writes registers only while busy is clear.
// RULE9: Non-data command keeps busy until done; data command only until latched.
// RULE10: An unselected device ignores all register reads and writes; the code still takes head register writes in legacy and bit-select modes.
// RULE11: Transfer command: set busy, block writes, latch, clear busy, allow writes.
// RULE12: Queuing accepts another command; without queuing a second command aborts.
// RULE13: Bit-select PIO: raise data request, interrupt only when selected.
// RULE14: Chip-select: raise request and own interrupt line when transfer possible.
// RULE15: PIO finish: drop data request, set error if any, interrupt.
// RULE16: Host selects interrupter, reads status, stays selected through transfer.
// RULE17: Completion shows busy and request clear with complete flag set.
// RULE18: Bit-select DMA: raise DMA request, interrupt only when selected.
// RULE19: DMA finish: drop DMA request, set error, interrupt (selection gated).
// RULE20: Tag of serviced or completed command sits in status upper byte.
// RULE21: Host pauses by dropping acknowledge, device by dropping request.
// RULE22: After a device pause, interrupt again when selected and request returns.
// RULE23: Upper status: bit 15 complete flag, bits 11 to 8 tag, rest reserved.
// RULE24: Chip-select: Device 1 drives second line, Device 0 the first, if enabled.
// RULE25: Overlapped accesses are 16 bits; other upper bytes read zero.
`timescale 1ns/1ps
module ovl_device_port
    import ovl_port_pkg::*;
#(
    parameter bit QUEUING = 1'b1
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [1:0] mode,
    input wire logic dev_id,
    input wire logic cs0_act,
    input wire logic cs1_act,
    input wire logic [2:0] da,
    input wire logic rd_stb,
    input wire logic wr_stb,
    input wire logic [15:0] wdata,
    input wire logic dmack,
    input wire logic word_stb,
    input wire logic xfer_ready,
    input wire logic xfer_pause,
    input wire logic xfer_last,
    input wire logic xfer_error,
    input wire logic exec_done,
    output logic [15:0] rdata,
    output logic rdata_oe_n,
    output logic drq,
    output logic dmarq,
    output logic intrq,
    output logic intrq_oe_n,
    output logic second_interrupt_request,
    output logic second_interrupt_request_oe_n,
    output logic [7:0] cmd_code,
    output logic [TAG_W-1:0] cmd_tag,
    output logic cmd_is_dma,
    output logic cmd_valid,
    output logic cmd_abort
);
    logic selected, cmd_block, ctl_block;
    logic intrq_d, intrq_en_d, intrq2_d, intrq2_en_d;
    state_t state_r, state_nxt;
    logic bsy_r, bsy_nxt, drq_r, drq_nxt, dmarq_r, dmarq_nxt;
    logic err_r, err_nxt, cc_r, cc_nxt, pend_r, pend_nxt;
    logic paused_r, paused_nxt, active_r, active_nxt;
    logic [7:0] devhead_r, devhead_nxt, devctl_r, devctl_nxt;
    logic [7:0] feat_r, feat_nxt, count_r, count_nxt;
    logic [15:0] cmdw_r, cmdw_nxt;
    logic [TAG_W-1:0] tag_r, tag_nxt;
    logic [3:0] lat_r, lat_nxt;
    logic [15:0] rdata_nxt;
    logic rdoe_n_nxt, cmd_valid_nxt, cmd_abort_nxt;
    logic cmd_wr, overlapped;

    ovl_select u_select (
        .mode(mode),
        .dev_id(dev_id),
        .dev_bit(devhead_r[DEV_BIT]),
        .cs0_act(cs0_act),
        .cs1_act(cs1_act),
        .selected(selected),
        .cmd_block(cmd_block),
        .ctl_block(ctl_block)
    );

    ovl_irq_gate u_irq (
        .mode(mode),
        .dev_id(dev_id),
        .selected(selected),
        .pending(pend_r),
        .nien(devctl_r[NIEN_BIT]),
        .intrq_d(intrq_d),
        .intrq_en_d(intrq_en_d),
        .intrq2_d(intrq2_d),
        .intrq2_en_d(intrq2_en_d)
    );

    // ****************************************
    // Command decode
    // ****************************************
    always_comb begin
        overlapped = (mode != MODE_LEGACY);
        cmd_wr = wr_stb && cmd_block && selected && da == ADDR_STATUS && !bsy_r; // RULE1 RULE10
    end

    // ****************************************
    // Command state and registers
    // ****************************************
    always_comb begin
        state_nxt = state_r;
        bsy_nxt = bsy_r;
        drq_nxt = drq_r;
        dmarq_nxt = dmarq_r;
        err_nxt = err_r;
        cc_nxt = cc_r;
        pend_nxt = pend_r;
        paused_nxt = paused_r;
        active_nxt = active_r;
        devhead_nxt = devhead_r;
        devctl_nxt = devctl_r;
        feat_nxt = feat_r;
        count_nxt = count_r;
        cmdw_nxt = cmdw_r;
        tag_nxt = tag_r;
        lat_nxt = lat_r;
        cmd_valid_nxt = 1'b0;
        cmd_abort_nxt = 1'b0;
        // Head register taken in legacy and bit-select modes even when deselected
        if (wr_stb && cmd_block && da == ADDR_DEVHEAD && !bsy_r
                && (selected || mode != MODE_CHIPSEL)) begin
            devhead_nxt = wdata[7:0]; // RULE2 RULE8
        end
        if (wr_stb && ctl_block && selected && da == ADDR_ALTSTAT) begin
            devctl_nxt = wdata[7:0]; // RULE25
        end
        if (wr_stb && cmd_block && selected && !bsy_r) begin
            if (da == ADDR_ERROR) feat_nxt = wdata[7:0]; // RULE25
            if (da == ADDR_COUNT) count_nxt = wdata[7:0];
        end
        if (rd_stb && selected && cmd_block && da == ADDR_STATUS) begin
            pend_nxt = 1'b0;
        end
        unique case (state_r)
            ST_IDLE, ST_WAIT, ST_XFER: begin
                if (cmd_wr) begin
                    if (active_r && !QUEUING) begin
                        cmd_abort_nxt = 1'b1; // RULE12
                        err_nxt = 1'b1;
                        drq_nxt = 1'b0;
                        dmarq_nxt = 1'b0;
                        cc_nxt = 1'b1;
                        pend_nxt = 1'b1;
                        active_nxt = 1'b0;
                        state_nxt = ST_IDLE;
                    end else begin
                        bsy_nxt = 1'b1; // RULE11
                        cmdw_nxt = wdata;
                        cc_nxt = 1'b0;
                        err_nxt = 1'b0;
                        lat_nxt = LATCH_CYCLES;
                        state_nxt = ST_LATCH;
                    end
                end else if (state_r == ST_WAIT && xfer_ready) begin
                    drq_nxt = !cmd_is_dma; // RULE13 RULE14
                    dmarq_nxt = cmd_is_dma; // RULE18
                    pend_nxt = 1'b1; // RULE14
                    paused_nxt = 1'b0;
                    state_nxt = ST_XFER;
                end else if (state_r == ST_XFER) begin
                    if (word_stb && xfer_last) begin
                        drq_nxt = 1'b0; // RULE15 RULE19
                        dmarq_nxt = 1'b0;
                        err_nxt = xfer_error;
                        cc_nxt = 1'b1; // RULE17
                        pend_nxt = 1'b1;
                        active_nxt = 1'b0;
                        state_nxt = ST_IDLE;
                    end else if (cmd_is_dma && dmarq_r && xfer_pause) begin
                        dmarq_nxt = 1'b0; // RULE21
                        paused_nxt = 1'b1;
                    end else if (paused_r && !dmarq_r && !xfer_pause && selected) begin
                        dmarq_nxt = 1'b1; // RULE22
                        pend_nxt = 1'b1;
                        paused_nxt = 1'b0;
                    end
                end
            end
            ST_LATCH: begin
                if (lat_r == 4'h1) begin
                    tag_nxt = count_r[3 +: TAG_W]; // RULE20
                    cmd_valid_nxt = 1'b1;
                    active_nxt = 1'b1;
                    if (is_data_r(cmdw_r) && overlapped) begin
                        bsy_nxt = 1'b0; // RULE3 RULE9
                        state_nxt = ST_WAIT;
                    end else begin
                        state_nxt = ST_EXEC; // RULE9
                    end
                end
                lat_nxt = lat_r - 4'h1;
            end
            ST_EXEC: begin
                if (exec_done) begin
                    bsy_nxt = 1'b0; // RULE9
                    cc_nxt = 1'b1; // RULE17
                    err_nxt = xfer_error;
                    pend_nxt = 1'b1;
                    active_nxt = 1'b0;
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
        if (state_r == ST_LATCH && xfer_ready && is_data_r(cmdw_r)) begin
            drq_nxt = !is_dma_r(cmdw_r); // RULE13 RULE18
            dmarq_nxt = is_dma_r(cmdw_r);
        end
        if (devctl_r[SRST_BIT]) begin
            state_nxt = ST_IDLE;
            bsy_nxt = 1'b0;
            drq_nxt = 1'b0;
            dmarq_nxt = 1'b0;
            active_nxt = 1'b0;
            pend_nxt = 1'b0;
        end
    end

    function automatic logic is_dma_r(input logic [15:0] w);
        is_dma_r = w[7:4] == 4'hC;
    endfunction

    function automatic logic is_data_r(input logic [15:0] w);
        is_data_r = w[7:4] == 4'hC || w[7:4] == 4'h2 || w[7:4] == 4'h3;
    endfunction

    // ****************************************
    // Read data path
    // ****************************************
    always_comb begin
        rdata_nxt = 16'h0000;
        rdoe_n_nxt = 1'b1;
        if (rd_stb && selected) begin // RULE10
            rdoe_n_nxt = 1'b0;
            if ((cmd_block && da == ADDR_STATUS) || (ctl_block && da == ADDR_ALTSTAT)) begin
                rdata_nxt[ST_BSY] = bsy_r; // RULE7
                rdata_nxt[ST_DRQ] = drq_r;
                rdata_nxt[ST_RDY] = !bsy_r;
                rdata_nxt[ST_ERR] = err_r;
                rdata_nxt[CC_BIT] = cc_r; // RULE23
                rdata_nxt[TAG_LSB +: TAG_W] = tag_r; // RULE20 RULE23
            end else if (cmd_block && da == ADDR_COUNT) begin
                rdata_nxt[7:0] = count_r; // RULE25
            end else if (cmd_block && da == ADDR_DEVHEAD) begin
                rdata_nxt[7:0] = devhead_r;
            end
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            state_r <= ST_IDLE;
            bsy_r <= 1'b0;
            drq_r <= 1'b0;
            dmarq_r <= 1'b0;
            err_r <= 1'b0;
            cc_r <= 1'b0;
            pend_r <= 1'b0;
            paused_r <= 1'b0;
            active_r <= 1'b0;
            devhead_r <= DEVHEAD_RESET;
            devctl_r <= DEVCTL_RESET;
            feat_r <= 8'h00;
            count_r <= 8'h00;
            cmdw_r <= 16'h0000;
            tag_r <= 4'h0;
            lat_r <= 4'h0;
            rdata <= 16'h0000;
            rdata_oe_n <= 1'b1;
            drq <= 1'b0;
            dmarq <= 1'b0;
            intrq <= 1'b0;
            intrq_oe_n <= 1'b1;
            second_interrupt_request <= 1'b0;
            second_interrupt_request_oe_n <= 1'b1;
            cmd_code <= 8'h00;
            cmd_tag <= 4'h0;
            cmd_is_dma <= 1'b0;
            cmd_valid <= 1'b0;
            cmd_abort <= 1'b0;
        end else begin
            state_r <= state_nxt;
            bsy_r <= bsy_nxt;
            drq_r <= drq_nxt;
            dmarq_r <= dmarq_nxt;
            err_r <= err_nxt;
            cc_r <= cc_nxt;
            pend_r <= pend_nxt;
            paused_r <= paused_nxt;
            active_r <= active_nxt;
            devhead_r <= devhead_nxt;
            devctl_r <= devctl_nxt;
            feat_r <= feat_nxt;
            count_r <= count_nxt;
            cmdw_r <= cmdw_nxt;
            tag_r <= tag_nxt;
            lat_r <= lat_nxt;
            rdata <= rdata_nxt;
            rdata_oe_n <= rdoe_n_nxt;
            drq <= drq_nxt;
            dmarq <= dmarq_nxt;
            intrq <= intrq_d;
            intrq_oe_n <= !intrq_en_d;
            second_interrupt_request <= intrq2_d;
            second_interrupt_request_oe_n <= !intrq2_en_d;
            if (cmd_valid_nxt) begin
                cmd_code <= cmdw_r[7:0];
                cmd_tag <= tag_nxt;
                cmd_is_dma <= is_dma_r(cmdw_r);
            end
            cmd_valid <= cmd_valid_nxt;
            cmd_abort <= cmd_abort_nxt;
        end
    end
endmodule // ovl_device_port

/* File: tb/ovl_device_port_checker.sv */
`timescale 1ns/1ps
module ovl_device_port_checker
    import ovl_port_pkg::*;
#(
    parameter bit QUEUING = 1'b1
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [1:0] mode,
    input wire logic dev_id,
    input wire logic cs0_act,
    input wire logic cs1_act,
    input wire logic [2:0] da,
    input wire logic rd_stb,
    input wire logic wr_stb,
    input wire logic word_stb,
    input wire logic xfer_pause,
    input wire logic xfer_last,
    input wire logic rdata_oe_n,
    input wire logic drq,
    input wire logic dmarq,
    input wire logic intrq_oe_n,
    input wire logic second_interrupt_request_oe_n,
    input wire logic cmd_valid,
    input wire logic cmd_abort
);
    // ****************************************
    // Port checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    a_unsel_read_quiet: assert property (rd_stb && mode == MODE_CHIPSEL && cs1_act != dev_id |=> rdata_oe_n)
        else $error("unselected read drove the bus");
    a_sel_read_answer: assert property (rd_stb && mode == MODE_CHIPSEL && cs0_act && cs1_act == dev_id
        && da == ADDR_STATUS |=> !rdata_oe_n)
        else $error("selected status read got no answer");
    a_read_oe_cause: assert property (!rdata_oe_n |-> $past(rd_stb))
        else $error("read data driven without a read");
    a_unsel_write_ignored: assert property (wr_stb && mode == MODE_CHIPSEL && cs1_act != dev_id
        && da == ADDR_STATUS |-> ##3 !cmd_valid)
        else $error("unselected command write was latched");
    a_latch_from_write: assert property (cmd_valid |-> $past(wr_stb, 3) && $past(da, 3) == ADDR_STATUS)
        else $error("command latched without a command write");
    a_dev0_line_only: assert property (mode == MODE_CHIPSEL && !dev_id |-> second_interrupt_request_oe_n)
        else $error("device 0 drove the second interrupt line");
    a_dev1_line_only: assert property (mode == MODE_CHIPSEL && dev_id |-> intrq_oe_n)
        else $error("device 1 drove the first interrupt line");
    a_dma_last_drop: assert property (dmarq && word_stb && xfer_last |=> !dmarq)
        else $error("dma request stayed after last word");
    a_pio_last_drop: assert property (drq && word_stb && xfer_last |=> !drq)
        else $error("data request stayed after last word");
    a_pause_drop: assert property ($rose(xfer_pause) |-> ##[1:2] !dmarq)
        else $error("dma request stayed during pause");
    a_no_abort_queued: assert property (QUEUING |-> !cmd_abort)
        else $error("queuing device aborted a command");
endmodule // ovl_device_port_checker

bind ovl_device_port ovl_device_port_checker #(.QUEUING(QUEUING)) chk_i (.*);

/* File: tb/host_dma_model.sv */
`timescale 1ns/1ps
module host_dma_model #(
    parameter int WORDS = 3,
    parameter int GAP = 1
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic en,
    input wire logic dmarq,
    output logic dmack,
    output logic word_stb,
    output logic xfer_last
);
    // ****************************************
    // Host dma engine
    // ****************************************
    int cnt;
    int gap;
    initial begin
        dmack = 1'b0;
        word_stb = 1'b0;
        xfer_last = 1'b0;
        cnt = 0;
        gap = GAP;
    end
    always @(negedge clk) begin
        word_stb <= 1'b0;
        xfer_last <= 1'b0;
        dmack <= dmarq && en && !reset;
        if (dmack && dmarq && en && !reset) begin
            if (gap == 0) begin
                cnt = cnt + 1;
                word_stb <= 1'b1;
                xfer_last <= (cnt == WORDS);
                gap = GAP;
                if (cnt == WORDS) begin
                    cnt = 0;
                end
            end else begin
                gap = gap - 1;
            end
        end
    end
endmodule // host_dma_model

/* File: tb/tb_ovl_device_port.sv */
`timescale 1ns/1ps
module tb_ovl_device_port;
    import ovl_port_pkg::*;
    // ****************************************
    // Bench
    // ****************************************
    logic clk, reset, dev_id, cs0_act, cs1_act, rd_stb, wr_stb, dmack, xfer_ready, xfer_pause, xfer_error;
    logic exec_done, pio_stb, pio_last, dma_stb, dma_last, dma_en;
    logic [1:0] mode;
    logic [2:0] da;
    logic [15:0] wdata, rdata, s;
    logic rdata_oe_n, drq, dmarq, intrq, intrq_oe_n, sir, sir_oe_n, cmd_is_dma, cmd_valid, cmd_abort;
    logic [7:0] cmd_code;
    logic [TAG_W-1:0] cmd_tag;
    int errors = 0;
    int num_checks = 0;

    ovl_device_port ovl_device_port_i (.clk(clk), .reset(reset), .mode(mode), .dev_id(dev_id),
        .cs0_act(cs0_act), .cs1_act(cs1_act), .da(da), .rd_stb(rd_stb), .wr_stb(wr_stb), .wdata(wdata),
        .dmack(dmack), .word_stb(pio_stb | dma_stb), .xfer_ready(xfer_ready), .xfer_pause(xfer_pause),
        .xfer_last(pio_last | dma_last), .xfer_error(xfer_error), .exec_done(exec_done), .rdata(rdata),
        .rdata_oe_n(rdata_oe_n), .drq(drq), .dmarq(dmarq), .intrq(intrq), .intrq_oe_n(intrq_oe_n),
        .second_interrupt_request(sir), .second_interrupt_request_oe_n(sir_oe_n), .cmd_code(cmd_code),
        .cmd_tag(cmd_tag), .cmd_is_dma(cmd_is_dma), .cmd_valid(cmd_valid), .cmd_abort(cmd_abort));
    host_dma_model host_dma_model_i (.clk(clk), .reset(reset), .en(dma_en), .dmarq(dmarq), .dmack(dmack),
        .word_stb(dma_stb), .xfer_last(dma_last));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wait_until(ref logic sig, input logic v);
        int n;
        n = 0;
        while (sig !== v && n < 60) begin
            @(negedge clk);
            n++;
        end
        if (sig !== v) begin
            errors++;
            $display("CHECK FAILED at %0t: wait timed out", $time);
            finish_test();
        end
    endtask

    task automatic do_reset(input logic [1:0] m, input logic id, input logic c0, input logic c1);
        @(negedge clk);
        reset = 1'b1;
        mode = m;
        dev_id = id;
        cs0_act = c0;
        cs1_act = c1;
        repeat (3) @(negedge clk);
        reset = 1'b0;
    endtask

    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(negedge clk);
        wr_stb = 1'b1;
        da = a;
        wdata = d;
        @(negedge clk);
        wr_stb = 1'b0;
    endtask

    task automatic rd(input logic [2:0] a);
        @(negedge clk);
        rd_stb = 1'b1;
        da = a;
        @(negedge clk);
        rd_stb = 1'b0;
        s = rdata;
    endtask

    task automatic t_dma();
        do_reset(MODE_CHIPSEL, 1'b0, 1'b1, 1'b0);
        wr(ADDR_COUNT, 16'h0028);
        wr(ADDR_STATUS, 16'h00C8);
        wait_until(cmd_valid, 1'b1);
        check({8'h00, cmd_code}, 16'h00C8);
        check(16'(cmd_tag), 16'h0005);
        check(16'(cmd_is_dma), 16'h0001);
        rd(ADDR_STATUS);
        check(s & 16'h0080, 16'h0000);
        xfer_ready = 1'b1;
        wait_until(dmarq, 1'b1);
        @(negedge clk);
        check({13'h0000, intrq, intrq_oe_n, sir_oe_n}, 16'h0005);
        rd(ADDR_STATUS);
        check(s & 16'h0F80, 16'h0500);
        xfer_pause = 1'b1;
        wait_until(dmarq, 1'b0);
        xfer_pause = 1'b0;
        wait_until(dmarq, 1'b1);
        @(negedge clk);
        check({14'h0000, intrq, intrq_oe_n}, 16'h0002);
        rd(ADDR_STATUS);
        check(s & 16'h0F88, 16'h0500);
        dma_en <= 1'b1;
        wait_until(dmarq, 1'b0);
        dma_en <= 1'b0;
        @(negedge clk);
        check({14'h0000, intrq, intrq_oe_n}, 16'h0002);
        rd(ADDR_STATUS);
        check(s & 16'h8F89, 16'h8500);
        xfer_ready = 1'b0;
    endtask

    task automatic t_pio();
        do_reset(MODE_CHIPSEL, 1'b1, 1'b1, 1'b1);
        wr(ADDR_COUNT, 16'h0018);
        wr(ADDR_STATUS, 16'h0020);
        wait_until(cmd_valid, 1'b1);
        check(16'(cmd_is_dma), 16'h0000);
        xfer_ready = 1'b1;
        wait_until(drq, 1'b1);
        @(negedge clk);
        check({13'h0000, sir, intrq_oe_n, sir_oe_n}, 16'h0006);
        rd(ADDR_STATUS);
        check(s & 16'h0088, 16'h0008);
        xfer_error = 1'b1;
        pio_stb = 1'b1;
        pio_last = 1'b1;
        @(negedge clk);
        pio_stb = 1'b0;
        pio_last = 1'b0;
        wait_until(drq, 1'b0);
        @(negedge clk);
        check({14'h0000, sir, sir_oe_n}, 16'h0002);
        rd(ADDR_STATUS);
        check(s & 16'h8F89, 16'h8301);
        xfer_error = 1'b0;
        xfer_ready = 1'b0;
    endtask

    task automatic t_unsel();
        do_reset(MODE_CHIPSEL, 1'b0, 1'b1, 1'b1);
        wr(ADDR_STATUS, 16'h00C8);
        repeat (4) begin
            @(negedge clk);
            check(16'(cmd_valid), 16'h0000);
        end
        rd(ADDR_STATUS);
        check(16'(rdata_oe_n), 16'h0001);
    endtask

    task automatic t_nondata();
        do_reset(MODE_CHIPSEL, 1'b0, 1'b1, 1'b0);
        wr(ADDR_STATUS, 16'h00E7);
        repeat (4) @(negedge clk);
        rd(ADDR_STATUS);
        check(s & 16'h0080, 16'h0080);
        exec_done = 1'b1;
        @(negedge clk);
        exec_done = 1'b0;
        repeat (2) @(negedge clk);
        rd(ADDR_STATUS);
        check(s & 16'h8089, 16'h8000);
    endtask

    task automatic t_bitsel();
        do_reset(MODE_BITSEL, 1'b1, 1'b1, 1'b0);
        wr(ADDR_DEVHEAD, 16'h0010);
        wr(ADDR_COUNT, 16'h0008);
        wr(ADDR_STATUS, 16'h00C8);
        wait_until(cmd_valid, 1'b1);
        rd(ADDR_STATUS);
        check(s & 16'h0080, 16'h0000);
        xfer_ready = 1'b1;
        wait_until(dmarq, 1'b1);
        @(negedge clk);
        check({14'h0000, intrq, intrq_oe_n}, 16'h0002);
        wr(ADDR_DEVHEAD, 16'h0000);
        @(negedge clk);
        check({14'h0000, intrq_oe_n, dmarq}, 16'h0003);
        rd(ADDR_STATUS);
        check(16'(rdata_oe_n), 16'h0001);
        wr(ADDR_DEVHEAD, 16'h0010);
        wr(ADDR_COUNT, 16'h0030);
        wr(ADDR_STATUS, 16'h00C8);
        wait_until(cmd_valid, 1'b1);
        check({11'h000, cmd_abort, cmd_tag}, 16'h0006);
        xfer_ready = 1'b0;
    endtask

    initial begin
        {reset, dev_id, cs0_act, cs1_act, rd_stb, wr_stb, xfer_ready, xfer_pause} = 8'h80;
        {xfer_error, exec_done, pio_stb, pio_last, dma_en} = 5'h00;
        mode = MODE_LEGACY;
        da = 3'h0;
        wdata = 16'h0000;
        t_dma();
        $display("t_dma done");
        t_pio();
        $display("t_pio done");
        t_unsel();
        $display("t_unsel done");
        t_nondata();
        $display("t_nondata done");
        t_bitsel();
        $display("t_bitsel done");
        finish_test();
    end
endmodule // tb_ovl_device_port
